// ==== core/tcrc_device.sv ====
// touch controller end: reset pulse qualification, soft reset, strap address,
// conversion group sequencer and the shared data-ready / touch interrupt pin
// assumes the host keeps to the reset pulse widths; adc_sample is same-clock logic
`timescale 1ns/10ps
// Operation
// - low at least 10 us with supply ok resets
// - low pulses under 5 us are ignored
// - pulses between 5 and 10 us avoided
// - spikes up to 20 ns filtered out
// - control byte bit D1 requests soft reset
// - one active-low pin, data or touch selectable
// - reset pin is active low
// - two straps give target address bits 0,1
// - host holds reset low through power-up
// - host hard-resets after noncompliant power cycles
// - host hard-resets after supply glitches
// - host pin for interrupt is input only
// - x, y triplets and pressure pair conversions
// - accepted reset restores all defaults
module tcrc_device #(
    parameter logic [4:0] ADDR_HI  = tcrc_pkg::ADDR_HI_DEFAULT,
    parameter int         CONV_CYC = tcrc_pkg::CONV_CYC_DEF
) (
    input  wire logic                        mclk,
    input  wire logic                        rst_b,
    tcrc_link_if.dev                         link,
    input  wire logic                        supply_ok,
    input  wire logic                        touch_present,
    input  wire logic                        target_addr_strap_bit0,
    input  wire logic                        target_addr_strap_bit1,
    input  wire logic [tcrc_pkg::DATA_W-1:0] adc_sample,
    output logic                             conv_valid,
    output logic [2:0]                       conv_id,
    output logic [tcrc_pkg::DATA_W-1:0]      conv_data,
    output logic                             in_reset,
    output logic                             reset_event
);

    localparam int CC_W = $clog2(CONV_CYC + 1);
    localparam logic [CC_W-1:0] CONV_LAST = CC_W'(CONV_CYC - 1);

    typedef struct packed {
        logic [1:0]                            rst_sync;
        logic [tcrc_pkg::FILT_LEN-1:0]         rst_hist;
        logic                                  rst_filt;
        logic [tcrc_pkg::CNT_W-1:0]            low_cnt;
        logic                                  hw_hold;
        logic [1:0]                            strap_s1;
        logic [1:0]                            strap_s2;
        logic [1:0]                            strap_warm;
        logic [1:0]                            strap;
        logic                                  strap_taken;
        logic                                  irq_sel;
        logic                                  data_avail;
        logic                                  irq_n;
        tcrc_pkg::tcrc_seq_t                   seq;
        logic [2:0]                            step;
        logic [2:0]                            last;
        logic [CC_W-1:0]                       conv_cnt;
        logic [tcrc_pkg::NUM_CONV-1:0][tcrc_pkg::DATA_W-1:0] data_reg;
        logic                                  conv_valid;
        logic [2:0]                            conv_id;
        logic [tcrc_pkg::DATA_W-1:0]           conv_data;
        logic                                  reset_event;
    } tcrc_dev_st_t;

    localparam tcrc_dev_st_t DEV_RST = '{
        rst_sync: 2'h3, rst_hist: '1, rst_filt: 1'b1, irq_n: 1'b1,
        seq: tcrc_pkg::SEQ_IDLE, default: '0};

    tcrc_dev_st_t cur;
    tcrc_dev_st_t nxt;
    logic         hw_fire;
    logic         sw_fire;
    logic         hit;
    logic [3:0]   func;

    // next-state logic for the whole end
    always_comb begin
        nxt         = cur;
        hw_fire     = 1'b0;
        sw_fire     = 1'b0;
        func        = link.bus_data[tcrc_pkg::FUNC_LSB +: tcrc_pkg::FUNC_W];
        nxt.conv_valid  = 1'b0;
        nxt.reset_event = 1'b0;

        // reset pin: synchronise, then spike filter; a lone sample never moves the level
        nxt.rst_sync = {cur.rst_sync[0], link.reset_n};
        nxt.rst_hist = {cur.rst_hist[tcrc_pkg::FILT_LEN-2:0], cur.rst_sync[1]};
        if (&cur.rst_hist) begin
            nxt.rst_filt = 1'b1;
        end else if (~|cur.rst_hist) begin
            nxt.rst_filt = 1'b0;
        end

        // low-width counter; a low level is the request, and a drop in supply restarts it
        if (cur.rst_filt || !supply_ok) begin
            nxt.low_cnt = '0;
            nxt.hw_hold = cur.hw_hold & ~cur.rst_filt;
        end else if (cur.low_cnt != tcrc_pkg::THRESH) begin
            nxt.low_cnt = cur.low_cnt + 1'b1;
            if (cur.low_cnt == tcrc_pkg::THRESH - 1'b1) begin
                hw_fire     = 1'b1;
                nxt.hw_hold = 1'b1;
            end
        end

        // strap capture after the synchronisers have filled
        nxt.strap_s1 = {target_addr_strap_bit1, target_addr_strap_bit0};
        nxt.strap_s2 = cur.strap_s1;
        if (!cur.strap_taken) begin
            if (cur.strap_warm == tcrc_pkg::STRAP_WAIT) begin
                nxt.strap       = cur.strap_s2;
                nxt.strap_taken = 1'b1;
            end else begin
                nxt.strap_warm = cur.strap_warm + 1'b1;
            end
        end

        // control byte decode; writes before the straps are known are not answered
        hit = link.bus_valid && cur.strap_taken && !cur.hw_hold &&
              (link.bus_addr == {ADDR_HI, cur.strap});
        if (hit) begin
            if (link.bus_data[tcrc_pkg::SOFT_RST_BIT]) begin
                sw_fire = 1'b1;
            end else begin
                nxt.irq_sel    = link.bus_data[tcrc_pkg::IRQ_SEL_BIT];
                nxt.data_avail = 1'b0;
                if (cur.seq == tcrc_pkg::SEQ_IDLE) begin
                    nxt.conv_cnt = '0;
                    nxt.seq      = tcrc_pkg::SEQ_CONVERT;
                    case (func)
                        tcrc_pkg::FUNC_XYZ: begin
                            nxt.step = tcrc_pkg::IDX_Y_END_NODE_FIRST;
                            nxt.last = tcrc_pkg::IDX_PRESSURE_SECOND;
                        end
                        tcrc_pkg::FUNC_XY: begin
                            nxt.step = tcrc_pkg::IDX_Y_END_NODE_FIRST;
                            nxt.last = tcrc_pkg::IDX_X_CURRENT_CONV;
                        end
                        tcrc_pkg::FUNC_X: begin
                            nxt.step = tcrc_pkg::IDX_X_END_NODE_FIRST;
                            nxt.last = tcrc_pkg::IDX_X_CURRENT_CONV;
                        end
                        tcrc_pkg::FUNC_Y: begin
                            nxt.step = tcrc_pkg::IDX_Y_END_NODE_FIRST;
                            nxt.last = tcrc_pkg::IDX_Y_CURRENT_CONV;
                        end
                        tcrc_pkg::FUNC_Z: begin
                            nxt.step = tcrc_pkg::IDX_PRESSURE_FIRST;
                            nxt.last = tcrc_pkg::IDX_PRESSURE_SECOND;
                        end
                        default: begin
                            nxt.seq = tcrc_pkg::SEQ_IDLE; // unknown codes start nothing
                        end
                    endcase
                end
            end
        end

        // sequencer: one conversion per slot, each CONV_CYC cycles long
        case (cur.seq)
            tcrc_pkg::SEQ_IDLE: begin
                nxt.conv_cnt = '0;
            end
            tcrc_pkg::SEQ_CONVERT: begin
                if (cur.conv_cnt == CONV_LAST) begin
                    nxt.conv_cnt            = '0;
                    nxt.data_reg[cur.step]  = adc_sample;
                    nxt.conv_valid          = 1'b1;
                    nxt.conv_id             = cur.step;
                    nxt.conv_data           = adc_sample;
                    if (cur.step == cur.last) begin
                        nxt.seq        = tcrc_pkg::SEQ_IDLE;
                        nxt.data_avail = 1'b1;
                    end else begin
                        nxt.step = cur.step + 1'b1;
                    end
                end else begin
                    nxt.conv_cnt = cur.conv_cnt + 1'b1;
                end
            end
            default: begin
                nxt.seq = tcrc_pkg::SEQ_IDLE;
            end
        endcase

        // shared interrupt pin, registered so it never glitches
        nxt.irq_n = cur.irq_sel ? ~touch_present : ~cur.data_avail;

        // any accepted reset, and the whole time the pin stays low after it
        if (hw_fire || sw_fire || cur.hw_hold) begin
            nxt.strap_warm  = '0;
            nxt.strap       = '0;
            nxt.strap_taken = 1'b0;
            nxt.irq_sel     = 1'b0;
            nxt.data_avail  = 1'b0;
            nxt.irq_n       = 1'b1;
            nxt.seq         = tcrc_pkg::SEQ_IDLE;
            nxt.step        = '0;
            nxt.last        = '0;
            nxt.conv_cnt    = '0;
            nxt.data_reg    = '0;
            nxt.conv_valid  = 1'b0;
            nxt.conv_id     = '0;
            nxt.conv_data   = '0;
            nxt.reset_event = hw_fire | sw_fire;
        end
    end

    // single state register
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cur <= DEV_RST;
        end else begin
            cur <= nxt;
        end
    end

    assign link.irq_n  = cur.irq_n;
    assign conv_valid  = cur.conv_valid;
    assign conv_id     = cur.conv_id;
    assign conv_data   = cur.conv_data;
    assign in_reset    = cur.hw_hold;
    assign reset_event = cur.reset_event;

endmodule // tcrc_device

// ==== core/tcrc_host.sv ====
// host end: power-up reset sequence, recovery resets, control byte writes,
// and a synchronised view of the device interrupt pin
// assumes the device end sits on the same link interface and mclk
`timescale 1ns/10ps
module tcrc_host #(
    parameter logic [4:0] ADDR_HI = tcrc_pkg::ADDR_HI_DEFAULT
) (
    input  wire logic                        mclk,
    input  wire logic                        rst_b,
    tcrc_link_if.host                        link,
    input  wire logic                        supply_ok,
    input  wire logic                        target_addr_strap_bit0,
    input  wire logic                        target_addr_strap_bit1,
    input  wire logic                        hw_reset_req,
    input  wire logic                        power_cycle_done,
    input  wire logic                        supply_glitch,
    input  wire logic                        soft_reset_req,
    input  wire logic                        cmd_req,
    input  wire logic [tcrc_pkg::FUNC_W-1:0] cmd_func,
    input  wire logic                        cmd_irq_sel,
    output logic                             busy,
    output logic                             irq_active
);

    typedef struct packed {
        tcrc_pkg::tcrc_host_st_t    st;
        logic [tcrc_pkg::CNT_W-1:0] cnt;
        logic                       reset_n;
        logic                       bus_valid;
        logic [6:0]                 bus_addr;
        logic [7:0]                 bus_data;
        logic [1:0]                 irq_sync;
        logic                       irq_active;
        logic                       busy;
    } tcrc_host_v_t;

    // reset low from the start: the device must never see an early release
    localparam tcrc_host_v_t HOST_RST = '{
        st: tcrc_pkg::H_POWERUP, irq_sync: 2'h3, busy: 1'b1, default: '0};

    tcrc_host_v_t cur;
    tcrc_host_v_t nxt;
    logic [7:0]   byte_v;

    // next-state logic
    always_comb begin
        nxt           = cur;
        byte_v        = '0;
        nxt.bus_valid = 1'b0;

        // interrupt pin is only ever sampled here, never driven
        nxt.irq_sync   = {cur.irq_sync[0], link.irq_n};
        nxt.irq_active = ~cur.irq_sync[1];

        case (cur.st)
            tcrc_pkg::H_POWERUP: begin
                nxt.reset_n = 1'b0;
                nxt.cnt     = '0;
                if (supply_ok) begin
                    nxt.st = tcrc_pkg::H_HOLD;
                end
            end
            tcrc_pkg::H_HOLD: begin
                nxt.reset_n = 1'b0;
                if (!supply_ok) begin
                    nxt.st = tcrc_pkg::H_POWERUP;
                end else if (cur.cnt == tcrc_pkg::HOLD - 1'b1) begin
                    nxt.reset_n = 1'b1;
                    nxt.st      = tcrc_pkg::H_RUN;
                end else begin
                    nxt.cnt = cur.cnt + 1'b1;
                end
            end
            tcrc_pkg::H_RUN: begin
                if (hw_reset_req || power_cycle_done || supply_glitch) begin
                    nxt.reset_n = 1'b0;
                    nxt.cnt     = '0;
                    nxt.st      = tcrc_pkg::H_HOLD;
                end else if (soft_reset_req) begin
                    byte_v[tcrc_pkg::SOFT_RST_BIT] = 1'b1;
                    nxt.bus_valid = 1'b1;
                    nxt.bus_data  = byte_v;
                end else if (cmd_req) begin
                    byte_v[tcrc_pkg::FUNC_LSB +: tcrc_pkg::FUNC_W] = cmd_func;
                    byte_v[tcrc_pkg::IRQ_SEL_BIT]                  = cmd_irq_sel;
                    nxt.bus_valid = 1'b1;
                    nxt.bus_data  = byte_v;
                end
            end
            default: begin
                nxt.st = tcrc_pkg::H_POWERUP;
            end
        endcase

        nxt.bus_addr = {ADDR_HI, target_addr_strap_bit1, target_addr_strap_bit0};
        nxt.busy     = (nxt.st != tcrc_pkg::H_RUN);
    end

    // single state register
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cur <= HOST_RST;
        end else begin
            cur <= nxt;
        end
    end

    assign link.reset_n   = cur.reset_n;
    assign link.bus_valid = cur.bus_valid;
    assign link.bus_addr  = cur.bus_addr;
    assign link.bus_data  = cur.bus_data;
    assign busy           = cur.busy;
    assign irq_active     = cur.irq_active;

endmodule // tcrc_host

// ==== shared/tcrc_link_if.sv ====
// link between host and touch controller: reset pin, interrupt pin, control byte strobe
// assumes one mclk for both ends; the testbench instantiates and joins it
`timescale 1ns/10ps
interface tcrc_link_if;
    logic       reset_n;
    logic       irq_n;
    logic       bus_valid;
    logic [6:0] bus_addr;
    logic [7:0] bus_data;

    modport dev  (input reset_n, input bus_valid, input bus_addr, input bus_data,
                  output irq_n);
    modport host (output reset_n, output bus_valid, output bus_addr, output bus_data,
                  input irq_n);
endinterface

// ==== shared/tcrc_pkg.sv ====
// constants and types shared by both ends of the touch controller reset link
// assumes both ends run on the same 40 MHz mclk
package tcrc_pkg;

    // clock and reset-pulse timing, times in ns
    localparam int CLK_NS        = 25;
    localparam int RST_REJECT_NS = 5000;
    localparam int RST_ACCEPT_NS = 10000;
    localparam int SPIKE_NS      = 20;

    // cycle counts derived from the times above
    localparam int REJECT_CYC = (RST_REJECT_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACCEPT_CYC = RST_ACCEPT_NS / CLK_NS;
    localparam int THRESH_CYC = (REJECT_CYC + ACCEPT_CYC) / 2;
    localparam int SPIKE_CYC  = (SPIKE_NS / CLK_NS < 1) ? 1 : SPIKE_NS / CLK_NS;
    localparam int FILT_LEN   = SPIKE_CYC + 1;
    localparam int HOLD_CYC   = (RST_ACCEPT_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W      = $clog2(HOLD_CYC + 1);

    localparam logic [CNT_W-1:0] THRESH = CNT_W'(THRESH_CYC);
    localparam logic [CNT_W-1:0] HOLD   = CNT_W'(HOLD_CYC);

    // control byte layout
    localparam int IRQ_SEL_BIT  = 0;
    localparam int SOFT_RST_BIT = 1;
    localparam int FUNC_LSB     = 3;
    localparam int FUNC_W       = 4;

    // converter function codes
    localparam logic [FUNC_W-1:0] FUNC_XYZ = 4'h0;
    localparam logic [FUNC_W-1:0] FUNC_XY  = 4'h1;
    localparam logic [FUNC_W-1:0] FUNC_X   = 4'h2;
    localparam logic [FUNC_W-1:0] FUNC_Y   = 4'h3;
    localparam logic [FUNC_W-1:0] FUNC_Z   = 4'h4;

    // conversion slots, in scan order (y group first)
    localparam logic [2:0] IDX_Y_END_NODE_FIRST  = 3'h0;
    localparam logic [2:0] IDX_Y_END_NODE_SECOND = 3'h1;
    localparam logic [2:0] IDX_Y_CURRENT_CONV    = 3'h2;
    localparam logic [2:0] IDX_X_END_NODE_FIRST  = 3'h3;
    localparam logic [2:0] IDX_X_END_NODE_SECOND = 3'h4;
    localparam logic [2:0] IDX_X_CURRENT_CONV    = 3'h5;
    localparam logic [2:0] IDX_PRESSURE_FIRST    = 3'h6;
    localparam logic [2:0] IDX_PRESSURE_SECOND   = 3'h7;
    localparam int         NUM_CONV              = 8;

    // target address upper bits; value is arbitrary
    localparam logic [4:0] ADDR_HI_DEFAULT = 5'h0c;
    localparam int         DATA_W          = 12;
    localparam int         CONV_CYC_DEF    = 16;
    localparam logic [1:0] STRAP_WAIT      = 2'h2;

    typedef enum logic [0:0] {SEQ_IDLE, SEQ_CONVERT} tcrc_seq_t;
    typedef enum logic [1:0] {H_POWERUP, H_HOLD, H_RUN} tcrc_host_st_t;

endpackage

// ==== verif/tcrc_link_asserts.sv ====
// assertions on the link between host end and device end
// assumes the link signals are sampled on mclk and cleared by rst_b
`timescale 1ns/10ps
module tcrc_link_asserts (
    input wire logic       mclk,
    input wire logic       rst_b,
    input wire logic       reset_n,
    input wire logic       irq_n,
    input wire logic       bus_valid,
    input wire logic [6:0] bus_addr,
    input wire logic [7:0] bus_data
);
    logic [9:0] low_cnt;
    logic       wr;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    // low samples of the reset pin; saturates so a stuck pin cannot wrap
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b)
            low_cnt <= 10'h000;
        else if (reset_n)
            low_cnt <= 10'h000;
        else if (low_cnt != 10'h3ff)
            low_cnt <= low_cnt + 10'h001;
    end

    // addressed function write in data-ready mode, no soft reset
    assign wr = bus_valid && (bus_addr[6:2] == tcrc_pkg::ADDR_HI_DEFAULT)
                && !bus_data[1] && !bus_data[0];

    a_hold_min: assert property ($rose(reset_n) |-> low_cnt >= 10'h190)
        else $error("reset pin released too early");
    a_long_low_quiet: assert property (low_cnt >= 10'h140 |-> irq_n)
        else $error("interrupt active during accepted reset");
    a_no_bus_reset: assert property (!reset_n |-> !bus_valid)
        else $error("bus write while reset pin low");
    a_rel_quiet: assert property ($rose(reset_n) |-> irq_n [*4])
        else $error("interrupt active after reset release");
    a_soft_defaults: assert property (bus_valid && bus_data[1]
        && bus_addr[6:2] == tcrc_pkg::ADDR_HI_DEFAULT |-> ##2 irq_n [*2])
        else $error("interrupt active after soft reset");
    a_xyz_irq_time: assert property (wr && bus_data[6:3] == 4'h0
        |-> ##2 irq_n [*7] ##[116:126] !irq_n)
        else $error("full scan data-ready timing wrong");
    a_z_irq_time: assert property (wr && bus_data[6:3] == 4'h4
        |-> ##2 irq_n [*7] ##[20:28] !irq_n)
        else $error("pressure pair data-ready timing wrong");
    a_bad_code_quiet: assert property (wr && bus_data[6:3] > 4'h4
        |-> ##2 irq_n [*7])
        else $error("data ready after unknown function code");
endmodule // tcrc_link_asserts

// ==== verif/touch_controller_reset_control_bench.sv ====
// self-checking bench: host and device joined by one link, plus a second
// device whose reset pin the bench drives to try short, unpowered and full-width pulses
`timescale 1ns/10ps
module touch_controller_reset_control_bench;
    logic        mclk, rst_b, touch, sup_a, sup_b, cmd_sel;
    logic        conv_valid, in_reset, reset_event, busy, irq_active;
    logic        in_reset_b, rev_b;
    logic [1:0]  dev_strap, host_strap;
    logic [4:0]  req;
    logic [3:0]  cmd_func;
    logic [2:0]  conv_id;
    logic [11:0] adc, conv_data;
    logic [15:0] mon_got, mon_exp;
    logic [15:0] notes[$];
    int          fail_count, cmp_count, nb_rst;
    int          seed = 48744;
    int          first[5] = '{0, 0, 3, 0, 6};
    int          last[5] = '{7, 5, 5, 2, 7};
    int          w[5] = '{1, 150, 199, 450, 450};
    logic        s[5] = '{1, 1, 1, 0, 1};

    tcrc_link_if link ();
    tcrc_link_if link_t ();

    tcrc_host i_tcrc_host (.mclk(mclk), .rst_b(rst_b), .link(link), .supply_ok(sup_a),
        .target_addr_strap_bit0(host_strap[0]), .target_addr_strap_bit1(host_strap[1]),
        .hw_reset_req(req[0]), .power_cycle_done(req[1]), .supply_glitch(req[2]),
        .soft_reset_req(req[3]), .cmd_req(req[4]), .cmd_func(cmd_func),
        .cmd_irq_sel(cmd_sel), .busy(busy), .irq_active(irq_active));
    tcrc_device i_tcrc_device (.mclk(mclk), .rst_b(rst_b), .link(link), .supply_ok(sup_a),
        .touch_present(touch), .target_addr_strap_bit0(dev_strap[0]),
        .target_addr_strap_bit1(dev_strap[1]), .adc_sample(adc), .conv_valid(conv_valid),
        .conv_id(conv_id), .conv_data(conv_data), .in_reset(in_reset),
        .reset_event(reset_event));
    tcrc_device i_tcrc_device_b (.mclk(mclk), .rst_b(rst_b), .link(link_t),
        .supply_ok(sup_b), .touch_present(touch), .target_addr_strap_bit0(dev_strap[0]),
        .target_addr_strap_bit1(dev_strap[1]), .adc_sample(adc), .conv_valid(),
        .conv_id(), .conv_data(), .in_reset(in_reset_b), .reset_event(rev_b));
    tcrc_link_asserts i_tcrc_link_asserts (.mclk(mclk), .rst_b(rst_b),
        .reset_n(link.reset_n), .irq_n(link.irq_n), .bus_valid(link.bus_valid),
        .bus_addr(link.bus_addr), .bus_data(link.bus_data));

    // 40 MHz clock
    always #12.5 mclk = ~mclk;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic pulse(input int b);
        @(posedge mclk);
        req[b] <= 1'b1;
        @(posedge mclk);
        req <= 5'h00;
    endtask

    // bounded wait for the host to leave its reset hold
    task automatic wait_idle();
        int n;
        n = 0;
        cyc(2);
        while (busy !== 1'b0 && n < 2000) begin
            @(posedge mclk);
            n++;
        end
        chk({15'h0, busy}, 16'h0000);
        // device still filters the release and then recaptures its straps
        cyc(10);
    endtask

    // function write; notes at most nmax expected slots, fresh sample per scan
    task automatic scan(input int code, input logic sel, input int nmax);
        logic [11:0] d;
        int          n;
        d = 12'($random(seed));
        n = 0;
        @(posedge mclk);
        adc <= d;
        cmd_func <= 4'(code);
        cmd_sel <= sel;
        req[4] <= 1'b1;
        if (code < 5)
            for (int i = first[code]; i <= last[code] && n < nmax; i++) begin
                notes.push_back({1'b0, 3'(i), d});
                n++;
            end
        @(posedge mclk);
        req <= 5'h00;
    endtask

    // every conversion or reset event takes the oldest note; extras hit ffff
    always @(posedge mclk) begin
        if (conv_valid === 1'b1 || reset_event === 1'b1) begin
            mon_got = reset_event ? 16'h8000 : {1'b0, conv_id, conv_data};
            mon_exp = (notes.size() > 0) ? notes.pop_front() : 16'hffff;
            chk(mon_got, mon_exp);
        end
        if (rev_b === 1'b1)
            nb_rst++;
    end

    // watchdog, far beyond the few thousand cycles the run needs
    initial begin
        #500000;
        fail_count++;
        end_sim();
    end

    initial begin
        {mclk, rst_b, touch, sup_a, cmd_sel, req, cmd_func, adc} = '0;
        {dev_strap, host_strap, fail_count, cmp_count, nb_rst} = '0;
        sup_b = 1'b1;
        link_t.reset_n = 1'b1;
        link_t.bus_valid = 1'b0;
        link_t.bus_addr = 7'h00;
        link_t.bus_data = 8'h00;
        notes.push_back(16'h8000);
        cyc(20);
        rst_b <= 1'b1;
        // supplies still settling: host must keep the pin low and stay busy
        cyc(30);
        chk({15'h0, busy}, 16'h0001);
        sup_a <= 1'b1;
        wait_idle();
        $display("power-up done");
        for (int c = 0; c <= 5; c++) begin
            scan(c, 1'b0, 8);
            cyc(150);
            chk({15'h0, irq_active}, 16'(c < 5));
        end
        $display("function codes done");
        scan(5, 1'b1, 0);
        @(posedge mclk);
        touch <= 1'b1;
        cyc(6);
        chk({15'h0, irq_active}, 16'h0001);
        touch <= 1'b0;
        cyc(6);
        chk({15'h0, irq_active}, 16'h0000);
        $display("touch mode done");
        scan(1, 1'b0, 2);
        notes.push_back(16'h8000);
        cyc(38);
        pulse(3);
        cyc(100);
        chk({15'h0, irq_active}, 16'h0000);
        $display("soft reset done");
        for (int k = 0; k < 3; k++) begin
            notes.push_back(16'h8000);
            pulse(k);
            cyc(350);
            chk({15'h0, in_reset}, 16'h0001);
            wait_idle();
        end
        dev_strap <= 2'h1;
        notes.push_back(16'h8000);
        pulse(0);
        wait_idle();
        cyc(10);
        scan(2, 1'b0, 0);
        cyc(100);
        chk({15'h0, irq_active}, 16'h0000);
        host_strap <= 2'h1;
        scan(2, 1'b0, 3);
        cyc(100);
        chk({15'h0, irq_active}, 16'h0001);
        $display("recovery and strap done");
        for (int i = 0; i < 5; i++) begin
            @(posedge mclk);
            sup_b <= s[i];
            link_t.reset_n <= 1'b0;
            cyc(w[i]);
            chk({15'h0, in_reset_b}, 16'(i == 4));
            link_t.reset_n <= 1'b1;
            cyc(20);
            chk(16'(nb_rst), 16'(i == 4));
        end
        $display("pulse widths done");
        chk(16'(notes.size()), 16'h0000);
        end_sim();
    end
endmodule // touch_controller_reset_control_bench
